/* File: rtl/dcwd_top.sv */
// Dual communication watchdog with register access and output safe-state gating
`timescale 1ns/1ps
`default_nettype none
module dcwd_top
    import dcwd_pkg::*;
#(
    parameter int NOUT = 2,
    parameter logic [DCWD_DW-1:0] MULT_RST = DCWD_MULT_RST,
    parameter logic [DCWD_DW-1:0] COUNT_RST = DCWD_COUNT_RST
) (
    input wire logic clk,
    input wire logic reset,
    input wire dcwd_req_s reg_req,
    output logic [DCWD_DW-1:0] reg_rdata,
    output logic reg_ack,
    input wire logic bus_exchange_ok,
    input wire logic local_access,
    input wire logic [NOUT-1:0] out_request,
    input wire logic [NOUT-1:0] out_safe_value,
    output logic [NOUT-1:0] out_drive,
    output logic safe_state,
    output logic bus_expired,
    output logic local_expired
);
    logic [DCWD_DW-1:0] mult_q;
    logic [DCWD_DW-1:0] local_cnt_q;
    logic [DCWD_DW-1:0] bus_cnt_q;
    logic [DCWD_DW-1:0] tick_cnt_q;
    logic [DCWD_DW-1:0] rdata_q;
    logic [NOUT-1:0] out_q;
    logic ack_q;
    logic tick;
    logic bus_exp;
    logic local_exp;
    logic [DCWD_DW:0] tick_len;

    function automatic logic hit(input dcwd_req_s r, input logic [DCWD_AW-1:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction

    // Registers hold their value unless the master writes them
    always_ff @(posedge clk) begin
        if (reset) begin
            mult_q <= MULT_RST;
            local_cnt_q <= COUNT_RST;
            bus_cnt_q <= COUNT_RST;
        end else begin
            if (hit(reg_req, DCWD_OFS_MULT)) begin
                mult_q <= reg_req.wdata;
            end
            if (hit(reg_req, DCWD_OFS_LOCAL)) begin
                local_cnt_q <= reg_req.wdata;
            end
            if (hit(reg_req, DCWD_OFS_BUS)) begin
                bus_cnt_q <= reg_req.wdata;
            end
        end
    end

    // Read back
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 16'h0000;
            ack_q <= 1'b0;
        end else begin
            ack_q <= reg_req.rd || reg_req.wr;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    DCWD_OFS_MULT: rdata_q <= mult_q;
                    DCWD_OFS_LOCAL: rdata_q <= local_cnt_q;
                    DCWD_OFS_BUS: rdata_q <= bus_cnt_q;
                    DCWD_OFS_STATUS: rdata_q <= {14'h0000, local_exp, bus_exp};
                    default: rdata_q <= 16'h0000;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_q;
    assign reg_ack = ack_q;

    // Shared tick divider: multiplier plus two base periods
    assign tick_len = {1'b0, mult_q} + {1'b0, DCWD_TICK_EXTRA};
    always_ff @(posedge clk) begin
        if (reset || hit(reg_req, DCWD_OFS_MULT)) begin
            tick_cnt_q <= 16'h0000;
        end else if ({1'b0, tick_cnt_q} + 17'h00001 >= tick_len) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end
    assign tick = ({1'b0, tick_cnt_q} + 17'h00001 >= tick_len);

    dcwd_timer #(.CW(DCWD_DW)) u_bus (
        .clk(clk),
        .reset(reset),
        .tick(tick),
        .kick(bus_exchange_ok),
        .count(bus_cnt_q),
        .disable_zero(1'b1),
        .expired(bus_exp)
    );

    dcwd_timer #(.CW(DCWD_DW)) u_local (
        .clk(clk),
        .reset(reset),
        .tick(tick),
        .kick(local_access),
        .count(local_cnt_q),
        .disable_zero(1'b0),
        .expired(local_exp)
    );

    assign bus_expired = bus_exp;
    assign local_expired = local_exp;
    assign safe_state = bus_exp || local_exp;

    // Output gating to the safe value
    always_ff @(posedge clk) begin
        if (reset) begin
            out_q <= '0;
        end else if (bus_exp || local_exp) begin
            out_q <= out_safe_value;
        end else begin
            out_q <= out_request;
        end
    end
    assign out_drive = out_q;

    // Output, expiry, register and tick checks
    chk_safe_outputs: assert property (@(posedge clk) disable iff (reset)
        (bus_exp || local_exp) |=> (out_drive == $past(out_safe_value)))
        else $error("outputs not forced to safe value");
    chk_zero_disables: assert property (@(posedge clk) disable iff (reset)
        (bus_cnt_q == 16'h0000) |-> !bus_exp)
        else $error("bus watchdog active with zero count");
    chk_kick_clears: assert property (@(posedge clk) disable iff (reset)
        bus_exchange_ok |=> !bus_exp)
        else $error("bus expiry not cleared by exchange");
    chk_local_kick: assert property (@(posedge clk) disable iff (reset)
        local_access |=> !local_exp)
        else $error("local expiry not cleared by access");
    chk_mult_write: assert property (@(posedge clk) disable iff (reset)
        hit(reg_req, DCWD_OFS_MULT) |=> (mult_q == $past(reg_req.wdata)))
        else $error("multiplier write lost");
    chk_count_hold: assert property (@(posedge clk) disable iff (reset)
        !hit(reg_req, DCWD_OFS_BUS) |=> $stable(bus_cnt_q))
        else $error("bus count changed without write");
    chk_read_back: assert property (@(posedge clk) disable iff (reset)
        (reg_req.rd && reg_req.addr == DCWD_OFS_LOCAL) |=> (reg_rdata == $past(local_cnt_q)))
        else $error("local count read back wrong");
    chk_tick_period: assert property (@(posedge clk) disable iff (reset)
        (tick && mult_q == 16'h0002 && !hit(reg_req, DCWD_OFS_MULT)) |=> !tick ##1 !tick)
        else $error("tick period wrong");
    chk_expire_status: assert property (@(posedge clk) disable iff (reset)
        $rose(bus_exp) |-> $past(tick))
        else $error("bus expiry without tick");

    // Register file checks
    chk_bus_write: assert property (@(posedge clk) disable iff (reset)
        hit(reg_req, DCWD_OFS_BUS) |=> (bus_cnt_q == $past(reg_req.wdata)))
        else $error("bus count write lost");
    chk_local_write: assert property (@(posedge clk) disable iff (reset)
        hit(reg_req, DCWD_OFS_LOCAL) |=> (local_cnt_q == $past(reg_req.wdata)))
        else $error("local count write lost");
    chk_local_hold: assert property (@(posedge clk) disable iff (reset)
        !hit(reg_req, DCWD_OFS_LOCAL) |=> $stable(local_cnt_q))
        else $error("local count changed without write");
    chk_mult_hold: assert property (@(posedge clk) disable iff (reset)
        !hit(reg_req, DCWD_OFS_MULT) |=> $stable(mult_q))
        else $error("multiplier changed without write");
    chk_read_mult: assert property (@(posedge clk) disable iff (reset)
        (reg_req.rd && reg_req.addr == DCWD_OFS_MULT) |=> (reg_rdata == $past(mult_q)))
        else $error("multiplier read back wrong");
    chk_read_bus: assert property (@(posedge clk) disable iff (reset)
        (reg_req.rd && reg_req.addr == DCWD_OFS_BUS) |=> (reg_rdata == $past(bus_cnt_q)))
        else $error("bus count read back wrong");
    chk_read_status: assert property (@(posedge clk) disable iff (reset)
        (reg_req.rd && reg_req.addr == DCWD_OFS_STATUS) |=> (reg_rdata == {14'h0000, $past(local_exp), $past(bus_exp)}))
        else $error("status read back wrong");

    // Register bus checks
    chk_ack_follows: assert property (@(posedge clk) disable iff (reset)
        (reg_req.rd || reg_req.wr) |=> reg_ack)
        else $error("access not acknowledged");
    chk_ack_idle: assert property (@(posedge clk) disable iff (reset)
        !(reg_req.rd || reg_req.wr) |=> !reg_ack)
        else $error("acknowledge without access");
    chk_rdata_hold: assert property (@(posedge clk) disable iff (reset)
        !reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without read");

    // Watchdog checks
    chk_normal_outputs: assert property (@(posedge clk) disable iff (reset)
        !(bus_exp || local_exp) |=> (out_drive == $past(out_request)))
        else $error("outputs not following request");
    chk_zero_outputs: assert property (@(posedge clk) disable iff (reset)
        (bus_cnt_q == 16'h0000 && !local_exp) |=> (out_drive == $past(out_request)))
        else $error("disabled bus watchdog forced safe value");
    chk_bus_sticky: assert property (@(posedge clk) disable iff (reset)
        (bus_exp && !bus_exchange_ok && !hit(reg_req, DCWD_OFS_BUS)) |=> bus_exp)
        else $error("bus expiry cleared without exchange");
    chk_local_sticky: assert property (@(posedge clk) disable iff (reset)
        (local_exp && !local_access) |=> local_exp)
        else $error("local expiry cleared without access");
    chk_local_tick: assert property (@(posedge clk) disable iff (reset)
        $rose(local_exp) |-> $past(tick))
        else $error("local expiry without tick");
    chk_mult_restart: assert property (@(posedge clk) disable iff (reset)
        hit(reg_req, DCWD_OFS_MULT) |=> !tick)
        else $error("tick divider not restarted");
    chk_tick_due: assert property (@(posedge clk) disable iff (reset)
        (tick && mult_q == 16'h0002 && !hit(reg_req, DCWD_OFS_MULT)) ##1 (!hit(reg_req, DCWD_OFS_MULT)) [*3]
        |=> tick)
        else $error("tick came late");

    // Scenario covers
    cov_bus_expire: cover property (@(posedge clk) disable iff (reset) $rose(bus_exp));
    cov_local_expire: cover property (@(posedge clk) disable iff (reset) $rose(local_exp));
    cov_recover: cover property (@(posedge clk) disable iff (reset) bus_exp ##1 !bus_exp);
    cov_local_recover: cover property (@(posedge clk) disable iff (reset) local_exp ##1 !local_exp);
    cov_bus_disabled: cover property (@(posedge clk) disable iff (reset) (bus_cnt_q == 16'h0000) && !bus_exchange_ok);
endmodule
`default_nettype wire

/* File: rtl/dcwd_pkg.sv */
// Package of constants and types for the dual communication watchdog
// Function
// - When monitored traffic stops longer than the timeout, outputs go to a preset safe value.
// - The bus traffic watchdog defaults to a 100 ms timeout.
// - The local interface watchdog also defaults to a 100 ms timeout.
// - One tick multiplier register at 0x400 sets the tick period for both watchdogs.
// - Each watchdog has its own count register, 0x410 local and 0x420 bus, combined with the multiplier.
// - A register not written keeps the value it already holds.
// - The master can read back multiplier and both counts at their fixed offsets.
// - Every successful bus exchange restarts the bus watchdog, and only such an exchange or a bus count of zero clears its expiry.
// - One tick lasts multiplier plus two periods of 40 ns, and the timeout is tick times count.
// - The local interface watchdog expires when no local access occurs for longer than its timeout.
// - A bus watchdog count of zero disables that watchdog and never forces the safe state.
package dcwd_pkg;
    localparam int DCWD_AW = 12;
    localparam int DCWD_DW = 16;
    localparam logic [DCWD_AW-1:0] DCWD_OFS_MULT = 12'h400;
    localparam logic [DCWD_AW-1:0] DCWD_OFS_LOCAL = 12'h410;
    localparam logic [DCWD_AW-1:0] DCWD_OFS_BUS = 12'h420;
    localparam logic [DCWD_AW-1:0] DCWD_OFS_STATUS = 12'h440;
    localparam int DCWD_STAT_BUS_BIT = 0;
    localparam int DCWD_STAT_LOCAL_BIT = 1;
    localparam int DCWD_CLK_NS = 40;
    localparam int DCWD_TIMEOUT_MS = 100;
    localparam logic [DCWD_DW-1:0] DCWD_MULT_RST = 16'h09c2;
    localparam logic [DCWD_DW-1:0] DCWD_COUNT_RST = 16'h03e8;
    localparam logic [DCWD_DW-1:0] DCWD_TICK_EXTRA = 16'h0002;
    // Check: (2498 + 2) * 40 ns * 1000 = 100 ms
    localparam int DCWD_DEFAULT_NS = (16'd2498 + 2) * DCWD_CLK_NS * 1000;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [DCWD_AW-1:0] addr;
        logic [DCWD_DW-1:0] wdata;
    } dcwd_req_s;
endpackage

/* File: rtl/dcwd_timer.sv */
// One watchdog timeout counter driven by the shared tick
`timescale 1ns/1ps
`default_nettype none
module dcwd_timer
    import dcwd_pkg::*;
#(
    parameter int CW = DCWD_DW
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic kick,
    input wire logic [CW-1:0] count,
    input wire logic disable_zero,
    output logic expired
);
    logic [CW-1:0] cnt_q;
    logic exp_q;
    logic off;
    assign off = disable_zero && (count == '0);
    assign expired = exp_q && !off;
    always_ff @(posedge clk) begin
        if (reset || kick || off) begin
            cnt_q <= '0;
        end else if (tick && !exp_q) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset || off) begin
            exp_q <= 1'b0;
        end else if (kick) begin
            exp_q <= 1'b0;
        end else if (tick && !exp_q && (cnt_q + 1'b1 >= count)) begin
            exp_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: test/dcwd_traffic_model.sv */
// Traffic model of the network master and the local processor
`timescale 1ns/1ps
`default_nettype none
module dcwd_traffic_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic bus_on,
    input wire logic local_on,
    output logic bus_exchange_ok,
    output logic local_access
);
    logic phase = 1'b0;
    initial begin
        bus_exchange_ok = 1'b0;
        local_access = 1'b0;
    end
    // Pulses on alternate cycles, launched off the falling edge
    always @(negedge clk) begin
        phase <= ~phase;
        bus_exchange_ok <= bus_on && !reset && phase;
        local_access <= local_on && !reset && !phase;
    end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Testbench for the dual communication watchdog
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dcwd_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    dcwd_req_s req = '0;
    logic [15:0] rdata;
    logic ack, bus_ok, loc_acc, safe, bus_exp, loc_exp;
    logic bus_on = 1'b1;
    logic loc_on = 1'b1;
    logic [1:0] drive;
    int miscompares = 0;
    int n_tests = 0;
    initial begin
        forever #20 clk = ~clk;
    end
    dcwd_top dcwd_top_inst (.clk(clk), .reset(reset), .reg_req(req), .reg_rdata(rdata), .reg_ack(ack),
        .bus_exchange_ok(bus_ok), .local_access(loc_acc), .out_request(2'b01), .out_safe_value(2'b10),
        .out_drive(drive), .safe_state(safe), .bus_expired(bus_exp), .local_expired(loc_exp));
    dcwd_traffic_model dcwd_traffic_model_inst (.clk(clk), .reset(reset), .bus_on(bus_on),
        .local_on(loc_on), .bus_exchange_ok(bus_ok), .local_access(loc_acc));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(negedge clk);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
        chk("reg_ack", 16'(ack), 16'h0001);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk("reg_rdata", rdata, e);
    endtask
    task automatic t_defaults;
        rd(DCWD_OFS_MULT, 16'h09c2);
        rd(DCWD_OFS_LOCAL, 16'h03e8);
        rd(DCWD_OFS_BUS, 16'h03e8);
        rd(12'h430, 16'h0000);
    endtask
    task automatic t_startup;
        acc(1'b1, DCWD_OFS_MULT, 16'h0002);
        acc(1'b1, DCWD_OFS_BUS, 16'h0003);
        rd(DCWD_OFS_MULT, 16'h0002);
        rd(DCWD_OFS_BUS, 16'h0003);
        rd(DCWD_OFS_LOCAL, 16'h03e8);
    endtask
    task automatic t_bus_expiry;
        cyc(40);
        chk("bus_expired", 16'(bus_exp), 16'h0000);
        bus_on = 1'b0;
        cyc(4);
        chk("bus_expired", 16'(bus_exp), 16'h0000);
        cyc(12);
        chk("bus_expired", 16'(bus_exp), 16'h0001);
        chk("local_expired", 16'(loc_exp), 16'h0000);
        chk("out_drive", 16'(drive), 16'h0002);
        chk("safe_state", 16'(safe), 16'h0001);
        rd(DCWD_OFS_STATUS, 16'h0001);
        bus_on = 1'b1;
        cyc(5);
        chk("bus_expired", 16'(bus_exp), 16'h0000);
        chk("out_drive", 16'(drive), 16'h0001);
        chk("safe_state", 16'(safe), 16'h0000);
    endtask
    task automatic t_local_expiry;
        acc(1'b1, DCWD_OFS_LOCAL, 16'h0002);
        loc_on = 1'b0;
        cyc(2);
        chk("local_expired", 16'(loc_exp), 16'h0000);
        cyc(12);
        chk("local_expired", 16'(loc_exp), 16'h0001);
        chk("bus_expired", 16'(bus_exp), 16'h0000);
        chk("out_drive", 16'(drive), 16'h0002);
        rd(DCWD_OFS_STATUS, 16'h0002);
        loc_on = 1'b1;
        cyc(5);
        chk("local_expired", 16'(loc_exp), 16'h0000);
        chk("out_drive", 16'(drive), 16'h0001);
    endtask
    task automatic t_bus_off;
        acc(1'b1, DCWD_OFS_BUS, 16'h0000);
        bus_on = 1'b0;
        cyc(60);
        chk("bus_expired", 16'(bus_exp), 16'h0000);
        chk("out_drive", 16'(drive), 16'h0001);
        rd(DCWD_OFS_STATUS, 16'h0000);
        bus_on = 1'b1;
    endtask
    task automatic end_sim;
        if (n_tests > 0 && miscompares == 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        cyc(3);
        reset = 1'b0;
        t_defaults;
        t_startup;
        t_bus_expiry;
        t_local_expiry;
        t_bus_off;
        end_sim;
    end
    initial begin
        #(40 * 3000);
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
